// *** inc/flash_host_consts.vh ***
`ifndef FLASH_HOST_CONSTS_VH
`define FLASH_HOST_CONSTS_VH

// Bus widths
`define ADDR_W 20
`define DATA_W 16

// Command addresses and codes
`define ADDR_UNLOCK1 20'h05555
`define ADDR_UNLOCK2 20'h02AAA
`define ADDR_QUERY_GEN 20'h00055
`define ADDR_MAKER 20'h00000
`define ADDR_PART 20'h00001
`define CODE_UNLOCK1 8'hAA
`define CODE_UNLOCK2 8'h55
`define CODE_PROGRAM 8'hA0
`define CODE_ERASE 8'h80
`define CODE_SECTOR 8'h30
`define CODE_BLOCK 8'h50
`define CODE_CHIP 8'h10
`define CODE_SEC_READ 8'h88
`define CODE_SEC_PROG 8'hA5
`define CODE_SEC_LOCK 8'h85
`define CODE_ID_ENTRY 8'h90
`define CODE_QUERY 8'h98
`define CODE_EXIT 8'hF0

// Erase target fields
`define SECTOR_LSB 11
`define BLOCK_LSB 15

// Host operation codes
`define OP_READ 4'h0
`define OP_PROGRAM 4'h1
`define OP_SECTOR_ERASE 4'h2
`define OP_BLOCK_ERASE 4'h3
`define OP_CHIP_ERASE 4'h4
`define OP_ID_ENTRY 4'h5
`define OP_QUERY_ENTRY 4'h6
`define OP_QUERY_GEN 4'h7
`define OP_EXIT 4'h8
`define OP_SEC_ENTRY 4'h9
`define OP_SEC_PROGRAM 4'hA
`define OP_SEC_LOCK 4'hB
`define OP_EXIT_SHORT 4'hC

// Bus timing in ns, cycles derived at 25 ns clock
`define CLK_NS 25
`define T_WP_NS 40
`define T_WP_CYC ((`T_WP_NS + `CLK_NS - 1) / `CLK_NS)
`define T_RC_NS 90
`define T_RC_CYC ((`T_RC_NS + `CLK_NS - 1) / `CLK_NS)
`define T_RP_NS 200
`define T_RP_CYC ((`T_RP_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// *** hw/flash_cmd_host.v ***
// How it works
// - Program preceded by three-write unlock load
// - Erase sent as complete six-write sequence
// - Upper data byte driven low during commands
// - Vendor query entry: three writes, 98H@5555H
// - Generic query entry: single 98H@55H write
// - Query mode held until host sends exit
// - Exit command returns device to read mode
// - Security program completion via toggle bit only
// - Lock-out blocks further user half programming
// - Security read entry: 88H@5555H, exit leaves
`timescale 1ns/100ps
`include "flash_host_consts.vh"

module flash_cmd_host (
  input wire clk, // 40 MHz clock
  input wire rst_n, // Async reset, active low
  input wire req_valid, // Operation request
  output wire req_ready, // Idle, request taken
  input wire [3:0] req_op, // Operation code
  input wire [`ADDR_W-1:0] req_addr, // Target address
  input wire [`DATA_W-1:0] req_data, // Program data
  input wire wp_low_req, // Request write-protect pin low
  output reg done, // One-cycle completion pulse
  output reg [`DATA_W-1:0] rd_data, // Read data
  output reg op_fail, // Program/erase timed out
  output reg [`ADDR_W-1:0] flash_addr, // Address pins
  output reg [`DATA_W-1:0] dq_out, // Data pins out
  output reg dq_oe_n, // Data output enable, low drives
  input wire [`DATA_W-1:0] dq_in, // Data pins in
  output reg ce_n, // Chip enable
  output reg oe_n, // Output enable
  output reg we_n, // Write enable
  output reg wp_n, // Write protect
  output reg rst_flash_n // Flash hardware reset
);

  parameter [23:0] POLL_LIMIT = 24'hFFFFFF; // Max toggle polls before giving up

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] S_RESET = 3'd0;
  localparam [2:0] S_IDLE = 3'd1;
  localparam [2:0] S_WR = 3'd2;
  localparam [2:0] S_WR_GAP = 3'd3;
  localparam [2:0] S_RD = 3'd4;
  localparam [2:0] S_POLL = 3'd5;
  localparam [2:0] S_DONE = 3'd6;

  reg [2:0] state;
  reg [3:0] op;
  reg [`ADDR_W-1:0] addr;
  reg [`DATA_W-1:0] data;
  reg [2:0] step;
  reg [2:0] nwrites;
  reg [3:0] cnt;
  reg [23:0] polls;
  reg poll_prev;
  reg poll_first;
  reg [`DATA_W-1:0] dq_s1;
  reg [`DATA_W-1:0] dq_s2;

  // Cycle counts are small; only the low bits feed the 4-bit counter
  localparam [31:0] T_WP_FULL = `T_WP_CYC;
  localparam [31:0] T_RC_FULL = `T_RC_CYC;
  localparam [31:0] T_RP_FULL = `T_RP_CYC;

  wire [3:0] t_wp = T_WP_FULL[3:0];
  wire [3:0] t_rc = T_RC_FULL[3:0];
  wire [3:0] t_rp = T_RP_FULL[3:0];

  assign req_ready = (state == S_IDLE);

  // ----------------------------------------
  // Command sequence tables
  // ----------------------------------------
  function [2:0] seq_len;
    input [3:0] o;
    begin
      case (o)
        `OP_PROGRAM, `OP_SEC_PROGRAM, `OP_SEC_LOCK: seq_len = 3'd4;
        `OP_SECTOR_ERASE, `OP_BLOCK_ERASE, `OP_CHIP_ERASE: seq_len = 3'd6;
        `OP_QUERY_GEN, `OP_EXIT_SHORT: seq_len = 3'd1;
        `OP_READ: seq_len = 3'd0;
        default: seq_len = 3'd3;
      endcase
    end
  endfunction

  function [7:0] cmd_code;
    input [3:0] o;
    begin
      case (o)
        `OP_PROGRAM: cmd_code = `CODE_PROGRAM;
        `OP_SEC_PROGRAM: cmd_code = `CODE_SEC_PROG;
        `OP_SEC_LOCK: cmd_code = `CODE_SEC_LOCK;
        `OP_ID_ENTRY: cmd_code = `CODE_ID_ENTRY;
        `OP_QUERY_ENTRY: cmd_code = `CODE_QUERY;
        `OP_SEC_ENTRY: cmd_code = `CODE_SEC_READ;
        `OP_EXIT: cmd_code = `CODE_EXIT;
        default: cmd_code = `CODE_ERASE;
      endcase
    end
  endfunction

  reg [`ADDR_W-1:0] w_addr;
  reg [7:0] w_code;
  reg [`DATA_W-1:0] w_data;

  // Address and data of write number "step"
  always @* begin
    w_addr = `ADDR_UNLOCK1;
    w_code = `CODE_UNLOCK1;
    if (op == `OP_QUERY_GEN) begin
      w_addr = `ADDR_QUERY_GEN;
      w_code = `CODE_QUERY;
    end else if (op == `OP_EXIT_SHORT) begin
      w_code = `CODE_EXIT;
    end else if (step == 3'd1 || step == 3'd4) begin
      w_addr = `ADDR_UNLOCK2;
      w_code = `CODE_UNLOCK2;
    end else if (step == 3'd2) begin
      w_code = cmd_code(op);
    end else if (step == 3'd5) begin
      if (op == `OP_SECTOR_ERASE) begin
        w_addr = {addr[`ADDR_W-1:`SECTOR_LSB], {`SECTOR_LSB{1'b0}}};
        w_code = `CODE_SECTOR;
      end else if (op == `OP_BLOCK_ERASE) begin
        w_addr = {addr[`ADDR_W-1:`BLOCK_LSB], {`BLOCK_LSB{1'b0}}};
        w_code = `CODE_BLOCK;
      end else begin
        w_code = `CODE_CHIP;
      end
    end else if (step == 3'd3 && (op == `OP_PROGRAM || op == `OP_SEC_PROGRAM || op == `OP_SEC_LOCK)) begin
      w_addr = addr;
    end
    // Erase keeps its fourth write as the second unlock opener at the fixed address
    // Upper byte driven to a valid level, never floated
    w_data = {8'h00, w_code};
    if (step == 3'd3 && (op == `OP_PROGRAM || op == `OP_SEC_PROGRAM))
      w_data = data;
    else if (step == 3'd3 && op == `OP_SEC_LOCK)
      w_data = 16'h0000;
    else if (step == 3'd3)
      w_data = {8'h00, `CODE_UNLOCK1};
  end

  wire needs_poll = (op == `OP_PROGRAM) || (op == `OP_SEC_PROGRAM) || (op == `OP_SEC_LOCK) ||
                    (op == `OP_SECTOR_ERASE) || (op == `OP_BLOCK_ERASE) || (op == `OP_CHIP_ERASE);

  // ----------------------------------------
  // Data pin synchroniser
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
    end else begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_RESET;
      op <= 4'h0;
      addr <= 20'h00000;
      data <= 16'h0000;
      step <= 3'd0;
      nwrites <= 3'd0;
      cnt <= 4'h0;
      polls <= 24'h000000;
      poll_prev <= 1'b0;
      poll_first <= 1'b1;
      done <= 1'b0;
      rd_data <= 16'h0000;
      op_fail <= 1'b0;
      flash_addr <= 20'h00000;
      dq_out <= 16'h0000;
      dq_oe_n <= 1'b1;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      wp_n <= 1'b1;
      rst_flash_n <= 1'b0;
    end else begin
      done <= 1'b0;
      wp_n <= ~wp_low_req;
      case (state)
        S_RESET: begin
          // Hold flash reset low long enough to abort anything running
          if (cnt >= t_rp) begin
            rst_flash_n <= 1'b1;
            cnt <= 4'h0;
            state <= S_IDLE;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        S_IDLE: begin
          if (req_valid) begin
            op <= req_op;
            addr <= req_addr;
            data <= req_data;
            step <= 3'd0;
            nwrites <= seq_len(req_op);
            cnt <= 4'h0;
            op_fail <= 1'b0;
            state <= (req_op == `OP_READ) ? S_RD : S_WR;
          end
        end
        S_WR: begin
          // Host is the only driver while the flash output is off
          flash_addr <= w_addr;
          dq_out <= w_data;
          dq_oe_n <= 1'b0;
          ce_n <= 1'b0;
          oe_n <= 1'b1;
          we_n <= 1'b0;
          if (cnt >= t_wp) begin
            we_n <= 1'b1; // Device latches on rising edge
            cnt <= 4'h0;
            state <= S_WR_GAP;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        S_WR_GAP: begin
          ce_n <= 1'b1;
          if (cnt >= t_wp) begin
            cnt <= 4'h0;
            dq_oe_n <= 1'b1;
            if (step + 3'd1 < nwrites) begin
              step <= step + 3'd1;
              state <= S_WR;
            end else if (needs_poll) begin
              poll_first <= 1'b1;
              polls <= 24'h000000;
              state <= S_POLL;
            end else begin
              state <= S_DONE;
            end
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        S_RD, S_POLL: begin
          // Reads through the pin path; in ID/query modes this returns table data
          if (state == S_RD)
            flash_addr <= addr;
          dq_oe_n <= 1'b1;
          ce_n <= 1'b0;
          oe_n <= 1'b0;
          we_n <= 1'b1;
          if (cnt >= t_rc + 4'd2) begin
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            cnt <= 4'h0;
            if (state == S_RD) begin
              rd_data <= dq_s2;
              state <= S_DONE;
            end else begin
              // Toggle bit only, valid for every program and erase kind
              poll_first <= 1'b0;
              poll_prev <= dq_s2[6];
              polls <= polls + 24'h000001;
              if (!poll_first && poll_prev == dq_s2[6]) begin
                state <= S_DONE;
              end else if (polls >= POLL_LIMIT) begin
                op_fail <= 1'b1;
                state <= S_DONE;
              end
            end
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        S_DONE: begin
          ce_n <= 1'b1;
          oe_n <= 1'b1;
          done <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // flash_cmd_host

// *** tb/flash_dev_model.sv ***
`timescale 1ns/100ps
`include "flash_host_consts.vh"
module flash_dev_model #(
  parameter [15:0] MAKER = 16'h00C3, // Arbitrary value
  parameter [15:0] PART = 16'h7E11, // Arbitrary value
  parameter [15:0] QDATA = 16'h0051,
  parameter [15:0] SDATA = 16'h5A3C
) (
  input wire [19:0] a, // Address
  input wire ce_n, // Chip enable
  input wire oe_n, // Output enable
  input wire we_n, // Write strobe
  input wire wp_n, // Protect
  input wire rst_n, // Reset pin
  input wire [15:0] hd, // Host data
  input wire hoe_n, // Host drives
  output wire [15:0] dq // Wire level
);
  reg [15:0] mem [0:15];
  reg [15:0] last = 16'h0000;
  reg [2:0] st;
  reg [1:0] md;
  reg [7:0] cmd;
  reg lock = 1'b0;
  integer rd = 0, stop = 0, i;
  wire busy = rd < stop;
  wire u5 = a[14:0] == 15'h5555;
  wire u2 = a[14:0] == 15'h2AAA;
  wire [7:0] d = hd[7:0];
  wire bad = a[19:15] == 5'h00 && !wp_n;
  wire [15:0] rv = busy ? {9'h000, rd[0], 6'h00} :
    md == 2'd1 ? (a[0] ? PART : MAKER) : md == 2'd2 ? QDATA :
    md == 2'd3 ? SDATA : mem[a[3:0]];
  // A released wire shows the inverse of the last value, so stale data never passes
  assign dq = !hoe_n ? hd : (!ce_n && !oe_n) ? rv : ~last;
  reg act = 1'b0;
  // A read ends when either strobe rises; both may rise in one time step
  always @(ce_n or oe_n) begin
    if (!ce_n && !oe_n) begin
      act = 1'b1;
    end else if (act) begin
      act = 1'b0;
      last = rv;
      rd = rd + 1;
    end
  end
  always @(posedge we_n or negedge rst_n) begin
    if (!rst_n) begin
      st <= 3'd0;
      md <= 2'd0;
      stop <= rd;
    end else if (!ce_n && !busy) begin
      case (st)
        3'd0: begin
          st <= (d == 8'hAA && u5) ? 3'd1 : 3'd0;
          if (d == `CODE_QUERY && a[14:0] == 15'h0055) md <= 2'd2;
          if (d == `CODE_EXIT) md <= 2'd0;
        end
        3'd1: st <= (d == 8'h55 && u2) ? 3'd2 : 3'd0;
        3'd2: begin
          cmd <= d;
          st <= !u5 ? 3'd0 : (d == 8'hA0 || d == 8'hA5 || d == 8'h85) ? 3'd3 : d == 8'h80 ? 3'd4 : 3'd0;
          if (u5) case (d)
            8'h90: md <= 2'd1;
            8'h98: md <= 2'd2;
            8'h88: md <= 2'd3;
            8'hF0: md <= 2'd0;
            default: ;
          endcase
        end
        3'd3: begin
          st <= 3'd0;
          if (cmd == 8'hA0 && !bad) begin
            mem[a[3:0]] <= hd;
            stop <= rd + 3;
          end
          if (cmd == 8'hA5 && !lock) stop <= rd + 3;
          if (cmd == 8'h85) lock <= 1'b1;
        end
        3'd4: st <= (d == 8'hAA && u5) ? 3'd5 : 3'd0;
        3'd5: st <= (d == 8'h55 && u2) ? 3'd6 : 3'd0;
        default: begin
          st <= 3'd0;
          if (!bad && (d == 8'h30 || d == 8'h50 || d == 8'h10)) begin
            for (i = 0; i < 16; i++) mem[i] <= 16'hFFFF;
            stop <= rd + 3;
          end
        end
      endcase
    end
  end
endmodule // flash_dev_model

// *** tb/flash_cmd_host_checker.sv ***
`timescale 1ns/100ps
`include "flash_host_consts.vh"
module flash_cmd_host_checker (
  input wire clk, // Clock
  input wire rst_n, // Reset
  input wire wp_low_req, // Protect request
  input wire [`ADDR_W-1:0] flash_addr, // Address
  input wire [`DATA_W-1:0] dq_out, // Data out
  input wire dq_oe_n, // Host drive
  input wire ce_n, // Chip enable
  input wire oe_n, // Output enable
  input wire we_n, // Write strobe
  input wire wp_n, // Protect pin
  input wire rst_flash_n // Flash reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_excl; !(!oe_n && !we_n); endproperty
  a_excl: assert property (p_excl) else $error("read and write strobes together");
  property p_we_ce; !we_n |-> !ce_n; endproperty
  a_we_ce: assert property (p_we_ce) else $error("write strobe without chip enable");
  property p_float; !oe_n |-> dq_oe_n; endproperty
  a_float: assert property (p_float) else $error("host drives during read");
  property p_wp; wp_n == !$past(wp_low_req); endproperty
  a_wp: assert property (p_wp) else $error("protect pin late or wrong");
  property p_pulse; $fell(we_n) |-> !we_n [*2] ##1 we_n; endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse length wrong");
  property p_upper; !we_n && flash_addr == `ADDR_UNLOCK1 |-> dq_out[15:8] == 8'h00; endproperty
  a_upper: assert property (p_upper) else $error("upper byte not low in command");
  property p_unl; !we_n && flash_addr == `ADDR_UNLOCK2 |-> dq_out[7:0] == `CODE_UNLOCK2; endproperty
  a_unl: assert property (p_unl) else $error("second unlock code wrong");
  property p_rst; $rose(rst_flash_n) |-> $past(rst_flash_n, 8) == 1'b0; endproperty
  a_rst: assert property (p_rst) else $error("flash reset pulse short");
  c_wr: cover property ($fell(we_n));
  c_wp: cover property (!wp_n && !we_n);
  c_rd: cover property ($fell(oe_n));
endmodule // flash_cmd_host_checker
bind flash_cmd_host flash_cmd_host_checker chk_u (.clk(clk), .rst_n(rst_n), .wp_low_req(wp_low_req),
  .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
  .wp_n(wp_n), .rst_flash_n(rst_flash_n));

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`include "flash_host_consts.vh"
module testbench;
  localparam [15:0] MK = 16'h00C3; // Arbitrary value
  localparam [15:0] PT = 16'h7E11; // Arbitrary value
  localparam [15:0] QD = 16'h0051;
  localparam [15:0] SD = 16'h5A3C;
  localparam [19:0] AD = 20'h10013;
  reg clk = 0, rst_n = 0, req_valid = 0, wp_low_req = 0;
  reg [3:0] req_op = 4'h0;
  reg [19:0] req_addr = 20'h00000;
  reg [15:0] req_data = 16'h0000;
  wire req_ready, done, op_fail, dq_oe_n, ce_n, oe_n, we_n, wp_n, rst_flash_n;
  wire [15:0] rd_data, dq_out, bus;
  wire [19:0] flash_addr;
  reg [16:0] notes [$];
  reg [16:0] nt;
  reg [31:0] seed = 32'hC159;
  reg [15:0] v;
  integer err_total = 0, samples_checked = 0, cyc = 0, i;
  initial forever #12.5 clk = ~clk;
  flash_cmd_host #(.POLL_LIMIT(24'h000020)) dut_u (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
    .wp_low_req(wp_low_req), .done(done), .rd_data(rd_data), .op_fail(op_fail), .flash_addr(flash_addr),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(bus), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .wp_n(wp_n),
    .rst_flash_n(rst_flash_n));
  flash_dev_model #(.MAKER(MK), .PART(PT), .QDATA(QD), .SDATA(SD)) dev_u (.a(flash_addr),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .wp_n(wp_n), .rst_n(rst_flash_n), .hd(dq_out),
    .hoe_n(dq_oe_n), .dq(bus));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cmp(input string nm, input [15:0] e, input [15:0] s);
    samples_checked++;
    if (e !== s) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Request is held from one falling edge to the next; the note goes in when the request is raised
  task op(input [3:0] o, input [19:0] a, input [15:0] dt, input c, input [15:0] e);
    @(negedge clk);
    while (!req_ready) @(negedge clk);
    req_valid = 1;
    req_op = o;
    req_addr = a;
    req_data = dt;
    notes.push_back({c, e});
    @(negedge clk);
    req_valid = 0;
  endtask
  task close_out;
    $display("errors %0d comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(negedge clk) if (done) begin
    nt = notes.pop_front();
    cmp("op_fail", 16'h0000, {15'h0000, op_fail});
    if (nt[16]) cmp("rd_data", nt[15:0], rd_data);
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      close_out;
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1;
    for (i = 2; i < 5; i++) begin
      seed = lfsr(seed);
      v = seed[15:0];
      op(`OP_PROGRAM, AD, v, 1'b0, 16'h0000);
      op(`OP_READ, AD, 16'h0000, 1'b1, v);
      op(i[3:0], AD, 16'h0000, 1'b0, 16'h0000);
      op(`OP_READ, AD, 16'h0000, 1'b1, 16'hFFFF);
    end
    wp_low_req = 1'b1;
    op(`OP_PROGRAM, 20'h00003, 16'h0000, 1'b0, 16'h0000);
    op(`OP_READ, 20'h00003, 16'h0000, 1'b1, 16'hFFFF);
    wp_low_req = 1'b0;
    op(`OP_ID_ENTRY, 20'h00000, 16'h0000, 1'b0, 16'h0000);
    op(`OP_READ, 20'h00000, 16'h0000, 1'b1, MK);
    op(`OP_READ, 20'h00001, 16'h0000, 1'b1, PT);
    op(`OP_EXIT, 20'h00000, 16'h0000, 1'b0, 16'h0000);
    op(`OP_READ, AD, 16'h0000, 1'b1, 16'hFFFF);
    op(`OP_QUERY_ENTRY, 20'h00000, 16'h0000, 1'b0, 16'h0000);
    op(`OP_READ, 20'h00010, 16'h0000, 1'b1, QD);
    op(`OP_EXIT_SHORT, 20'h00000, 16'h0000, 1'b0, 16'h0000);
    op(`OP_READ, AD, 16'h0000, 1'b1, 16'hFFFF);
    op(`OP_QUERY_GEN, 20'h00000, 16'h0000, 1'b0, 16'h0000);
    op(`OP_READ, 20'h00010, 16'h0000, 1'b1, QD);
    op(`OP_EXIT, 20'h00000, 16'h0000, 1'b0, 16'h0000);
    op(`OP_SEC_ENTRY, 20'h00000, 16'h0000, 1'b0, 16'h0000);
    op(`OP_READ, 20'h00008, 16'h0000, 1'b1, SD);
    op(`OP_SEC_PROGRAM, 20'h00008, v, 1'b0, 16'h0000);
    op(`OP_SEC_LOCK, 20'h00000, 16'h0000, 1'b0, 16'h0000);
    op(`OP_SEC_PROGRAM, 20'h00008, v, 1'b0, 16'h0000);
    op(`OP_EXIT, 20'h00000, 16'h0000, 1'b0, 16'h0000);
    op(`OP_READ, AD, 16'h0000, 1'b1, 16'hFFFF);
    while (notes.size() != 0) @(negedge clk);
    close_out;
  end
endmodule // testbench
